// ===== hw/tsl_pkg.sv
/*
  Shared constants and carrier types for the temperature sensor limit and
  two-wire slave logic: pointer codes, configuration layout, reset values,
  conversion timing and the state records of both clock domains.
  Assumes nothing of its surroundings; it holds definitions only.
*/
package tsl_pkg;

  // ****************************************************************
  // Register pointers and word layout
  // ****************************************************************
  localparam logic [1:0]  PTR_TEMP      = 2'h0;
  localparam logic [1:0]  PTR_CFG       = 2'h1;
  localparam logic [1:0]  PTR_LOW       = 2'h2;
  localparam logic [1:0]  PTR_HIGH      = 2'h3;
  localparam int          VAL_W         = 12;
  localparam logic [3:0]  WORD_PAD      = 4'h0;
  localparam int          VAL_LSB       = 4;

  // Configuration word bit positions
  localparam int          CFG_UNDER_BIT = 4;
  localparam int          CFG_OVER_BIT  = 5;
  localparam int          CFG_RATE_LSB  = 6;
  localparam int          CFG_INTR_BIT  = 9;

  // ****************************************************************
  // Rate codes and reset values
  // ****************************************************************
  localparam logic [1:0]  RATE_0P25     = 2'h0;
  localparam logic [1:0]  RATE_1        = 2'h1;
  localparam logic [1:0]  RATE_4        = 2'h2;
  localparam logic [1:0]  RATE_16       = 2'h3;
  localparam logic [1:0]  RATE_RESET    = RATE_1;
  localparam logic [11:0] UPPER_RESET   = 12'h7ff;
  localparam logic [11:0] LOWER_RESET   = 12'h800;
  localparam logic [11:0] TEMP_RESET    = 12'h000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_MHZ       = 200;
  localparam int          CONV_TIME_US  = 22000;
  localparam int          PERIOD_US_0P25 = 4000000;
  localparam int          PERIOD_US_1   = 1000000;
  localparam int          PERIOD_US_4   = 250000;
  localparam int          PERIOD_US_16  = 62500;
  localparam int          CONV_CYC      = CONV_TIME_US * CLK_MHZ;
  localparam int          PERIOD_CYC_0P25 = PERIOD_US_0P25 * CLK_MHZ;
  localparam int          PERIOD_CYC_1  = PERIOD_US_1 * CLK_MHZ;
  localparam int          PERIOD_CYC_4  = PERIOD_US_4 * CLK_MHZ;
  localparam int          PERIOD_CYC_16 = PERIOD_US_16 * CLK_MHZ;

  // ****************************************************************
  // Bus addresses and events
  // ****************************************************************
  // Fixed slave address bits; value is arbitrary
  localparam logic [6:0]  BASE_ADDR     = 7'h48;
  localparam logic [6:0]  ARA_ADDR      = 7'h0c;
  localparam logic [6:0]  GC_ADDR       = 7'h00;
  localparam logic [7:0]  GC_RESET_CMD  = 8'h06;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam int          EV_WR         = 0;
  localparam int          EV_RD         = 1;
  localparam int          EV_ARA        = 2;
  localparam int          EV_GC         = 3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [7:0] {
    L_IDLE  = 8'h01,
    L_ADDR  = 8'h02,
    L_AACK  = 8'h04,
    L_WBYTE = 8'h08,
    L_WACK  = 8'h10,
    L_RBYTE = 8'h20,
    L_RACK  = 8'h40,
    L_WAIT  = 8'h80
  } tsl_lstate_t;

  typedef struct packed {
    logic [1:0]  ptr;
    logic [15:0] data;
  } tsl_wr_t;

  typedef struct packed {
    logic [1:0]  rate;
    logic        intr_mode;
    logic        over;
    logic        under;
    logic [11:0] upper;
    logic [11:0] lower;
    logic [11:0] temp;
    logic [31:0] cnt;
    logic        converting;
    logic        alert;
    logic        alert_out;
    logic [15:0] rd_word;
    logic        rd_ack_tgl;
    logic [3:0]  ev_prev;
  } tsl_core_t;

  typedef struct packed {
    tsl_lstate_t st;
    logic        scl_prev;
    logic        sda_prev;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic [1:0]  byte_idx;
    logic [1:0]  ptr;
    logic [6:0]  my_addr;
    logic        rd_mode;
    logic        ara;
    logic        gc;
    logic        lsb_next;
    logic [7:0]  msb;
    tsl_wr_t     wr;
    logic [3:0]  ev_tgl;
    logic        ack_prev;
    logic [15:0] rd_hold;
    logic        sda_oe;
    logic        sda_out;
  } tsl_link_t;

endpackage : tsl_pkg

// ===== hw/tsl_sync.sv
/*
  Two flip-flop synchroniser for a group of independent levels or toggles.
  Assumes each bit changes at most once per few destination clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module tsl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta;

  // No reset: pure data pipeline, settles within two edges
  always_ff @(posedge clk) begin
    meta <= d;
    q    <= meta;
  end

endmodule : tsl_sync

`default_nettype wire

// ===== hw/tsl_sensor.sv
/*
  Temperature sensor digital core: conversion timer, limit compare, alert
  pin and a two-wire slave with pointer register.
  Assumes ref_clk at 200 MHz, a free-running link_clk well above the bus
  rate, adc_result driven from ref_clk logic, and external pull-ups on
  the open-drain lines.
*/
`timescale 1ns/1ps
`default_nettype none

module tsl_sensor #(
  parameter logic [31:0] CONV_CYCLES  = 32'(tsl_pkg::CONV_CYC),
  parameter logic [31:0] PERIOD_0P25  = 32'(tsl_pkg::PERIOD_CYC_0P25),
  parameter logic [31:0] PERIOD_1     = 32'(tsl_pkg::PERIOD_CYC_1),
  parameter logic [31:0] PERIOD_4     = 32'(tsl_pkg::PERIOD_CYC_4),
  parameter logic [31:0] PERIOD_16    = 32'(tsl_pkg::PERIOD_CYC_16)
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        link_clk,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe,
  input  wire logic        address_select_pin,
  input  wire logic [11:0] adc_result,
  output var  logic        conv_active,
  output var  logic        limit_event_pin_out,
  output var  logic        limit_event_pin_oe
);

  // ****************************************************************
  // Reset images
  // ****************************************************************
  // starts converting, window open, zero
  localparam tsl_pkg::tsl_core_t CORE_RST = '{
    rate:       tsl_pkg::RATE_RESET,
    upper:      tsl_pkg::UPPER_RESET,
    lower:      tsl_pkg::LOWER_RESET,
    temp:       tsl_pkg::TEMP_RESET,
    converting: 1'b1,
    default:    '0
  };

  localparam tsl_pkg::tsl_link_t LINK_RST = '{
    st:       tsl_pkg::L_IDLE,
    scl_prev: 1'b1,
    sda_prev: 1'b1,
    ptr:      tsl_pkg::PTR_TEMP,
    default:  '0
  };

  tsl_pkg::tsl_core_t c;
  tsl_pkg::tsl_core_t next_c;
  tsl_pkg::tsl_link_t l;
  tsl_pkg::tsl_link_t next_l;

  logic [3:0]  ev_s;
  logic [3:0]  ev_hit;
  logic        over_hit;
  logic        under_hit;
  logic [1:0]  back_s;
  logic [3:0]  pin_s;
  logic        scl_s;
  logic        sda_s;
  logic        addr_s;
  logic        link_rst_n;
  logic        alert_s;
  logic        ack_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic        byte_done;
  logic        hit_own;
  logic        hit_ara;
  logic        hit_gc;
  logic [7:0]  next_byte;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // period length per rate code
  function automatic logic [31:0] period_of(input logic [1:0] rate);
    case (rate)
      tsl_pkg::RATE_0P25: period_of = PERIOD_0P25;
      tsl_pkg::RATE_1:    period_of = PERIOD_1;
      tsl_pkg::RATE_4:    period_of = PERIOD_4;
      default:            period_of = PERIOD_16;
    endcase
  endfunction : period_of

  // 12-bit values are left-justified, low nibble reads zero
  function automatic logic [15:0] reg_word(input logic [1:0]         ptr,
                                           input tsl_pkg::tsl_core_t s);
    logic [15:0] w;
    w = '0;
    case (ptr)
      tsl_pkg::PTR_TEMP: w = {s.temp, tsl_pkg::WORD_PAD};
      tsl_pkg::PTR_CFG: begin
        w[tsl_pkg::CFG_INTR_BIT]        = s.intr_mode;
        w[tsl_pkg::CFG_RATE_LSB +: 2]   = s.rate;
        w[tsl_pkg::CFG_OVER_BIT]        = s.over;
        w[tsl_pkg::CFG_UNDER_BIT]       = s.under;
      end
      tsl_pkg::PTR_LOW:  w = {s.lower, tsl_pkg::WORD_PAD};
      default:           w = {s.upper, tsl_pkg::WORD_PAD};
    endcase
    return w;
  endfunction : reg_word

  // ****************************************************************
  // Crossings
  // ****************************************************************
  tsl_sync #(.W(4)) u_ev_sync (
    .clk (ref_clk),
    .d   (l.ev_tgl),
    .q   (ev_s)
  );

  tsl_sync #(.W(2)) u_back_sync (
    .clk (link_clk),
    .d   ({c.alert, c.rd_ack_tgl}),
    .q   (back_s)
  );

  tsl_sync #(.W(4)) u_pin_sync (
    .clk (link_clk),
    .d   ({reset_n, address_select_pin, sda_in, scl_in}),
    .q   (pin_s)
  );

  assign scl_s      = pin_s[0];
  assign sda_s      = pin_s[1];
  assign addr_s     = pin_s[2];
  assign link_rst_n = pin_s[3];
  assign ack_s      = back_s[0];
  assign alert_s    = back_s[1];

  // ****************************************************************
  // Core domain: conversion, limits, registers
  // ****************************************************************
  // values are counts of 0.0625 degrees, compared signed
  assign over_hit  = $signed(adc_result) > $signed(c.upper);
  assign under_hit = $signed(adc_result) < $signed(c.lower);
  assign ev_hit    = ev_s ^ c.ev_prev;

  always_comb begin
    next_c           = c;
    next_c.ev_prev   = ev_s;
    next_c.alert_out = 1'b0;

    // Write data is held by the link side until after its toggle lands
    if (ev_hit[tsl_pkg::EV_WR]) begin
      case (l.wr.ptr)
        tsl_pkg::PTR_CFG: begin
          next_c.rate      = l.wr.data[tsl_pkg::CFG_RATE_LSB +: 2];
          next_c.intr_mode = l.wr.data[tsl_pkg::CFG_INTR_BIT];
        end
        // upper twelve bits carry the limit
        tsl_pkg::PTR_LOW:  next_c.lower = l.wr.data[tsl_pkg::VAL_LSB +: tsl_pkg::VAL_W];
        tsl_pkg::PTR_HIGH: next_c.upper = l.wr.data[tsl_pkg::VAL_LSB +: tsl_pkg::VAL_W];
        default: ;
      endcase
    end

    if (ev_hit[tsl_pkg::EV_RD]) begin
      next_c.rd_word    = reg_word(l.ptr, c);
      next_c.rd_ack_tgl = ~c.rd_ack_tgl;
      // config read clears flags and pin in interrupt mode
      if (l.ptr == tsl_pkg::PTR_CFG && c.intr_mode) begin
        next_c.over  = 1'b0;
        next_c.under = 1'b0;
        next_c.alert = 1'b0;
      end
    end

    // alert response releases the pin only, and only in interrupt mode
    if (ev_hit[tsl_pkg::EV_ARA] && c.intr_mode) begin
      next_c.alert = 1'b0;
    end

    // conversion, then idle until the period ends
    if (c.cnt == CONV_CYCLES - 32'h0000_0001) begin
      next_c.converting = 1'b0;
      // result and flags land in one edge
      next_c.temp = adc_result;
      if (c.intr_mode) begin
        // sticky flags; set beats a same-edge clear
        next_c.over  = next_c.over | over_hit;
        next_c.under = next_c.under | under_hit;
        next_c.alert = next_c.alert | over_hit | under_hit;
      end else begin
        // both clear when inside the window
        next_c.over  = over_hit;
        next_c.under = under_hit;
      end
    end

    // period end checked against the current rate every cycle
    if (c.cnt >= period_of(c.rate) - 32'h0000_0001) begin
      next_c.cnt        = '0;
      next_c.converting = 1'b1;
    end else begin
      next_c.cnt = c.cnt + 32'h0000_0001;
    end

    // Comparator mode: pin follows the flags
    if (!c.intr_mode) begin
      next_c.alert = next_c.over | next_c.under;
    end

    if (ev_hit[tsl_pkg::EV_GC]) begin
      next_c         = CORE_RST;
      next_c.ev_prev = ev_s;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      c <= CORE_RST;
    end else begin
      c <= next_c;
    end
  end

  // ****************************************************************
  // Link domain: two-wire slave
  // ****************************************************************
  assign scl_rise  = scl_s & ~l.scl_prev;
  assign scl_fall  = ~scl_s & l.scl_prev;
  assign bus_start = scl_s & l.scl_prev & l.sda_prev & ~sda_s;
  assign bus_stop  = scl_s & l.scl_prev & ~l.sda_prev & sda_s;
  assign byte_done = l.bit_cnt == tsl_pkg::BYTE_BITS;
  assign hit_own   = l.shreg[7:1] == l.my_addr;
  assign hit_ara   = l.shreg[0] & (l.shreg[7:1] == tsl_pkg::ARA_ADDR) & alert_s;
  assign hit_gc    = ~l.shreg[0] & (l.shreg[7:1] == tsl_pkg::GC_ADDR);
  assign next_byte = l.lsb_next ? l.rd_hold[7:0] : l.rd_hold[15:8];

  always_comb begin
    next_l          = l;
    next_l.scl_prev = scl_s;
    next_l.sda_prev = sda_s;
    next_l.ack_prev = ack_s;
    next_l.sda_out  = 1'b0;
    if (ack_s != l.ack_prev) begin
      next_l.rd_hold = c.rd_word;
    end

    if (bus_start) begin
      next_l.st       = tsl_pkg::L_ADDR;
      next_l.bit_cnt  = '0;
      next_l.byte_idx = '0;
      next_l.sda_oe   = 1'b0;
      // address pin caught at every start
      next_l.my_addr  = tsl_pkg::BASE_ADDR | {6'h00, addr_s};
    end else if (bus_stop) begin
      next_l.st     = tsl_pkg::L_IDLE;
      next_l.sda_oe = 1'b0;
    end else begin
      case (l.st)
        tsl_pkg::L_ADDR, tsl_pkg::L_WBYTE: begin
          if (scl_rise) begin
            next_l.shreg   = {l.shreg[6:0], sda_s};
            next_l.bit_cnt = l.bit_cnt + 4'h1;
          end else if (scl_fall && byte_done && l.st == tsl_pkg::L_ADDR) begin
            // answer only as an addressed slave
            if (hit_own || hit_ara || hit_gc) begin
              next_l.st      = tsl_pkg::L_AACK;
              next_l.sda_oe  = 1'b1;
              next_l.rd_mode = l.shreg[0];
              next_l.ara     = hit_ara;
              next_l.gc      = hit_gc & ~hit_own;
              // read request fetches the pointed word
              if (hit_own && l.shreg[0]) begin
                next_l.ev_tgl[tsl_pkg::EV_RD] = ~l.ev_tgl[tsl_pkg::EV_RD];
              end
              if (hit_ara) begin
                next_l.ev_tgl[tsl_pkg::EV_ARA] = ~l.ev_tgl[tsl_pkg::EV_ARA];
              end
            end else begin
              next_l.st = tsl_pkg::L_WAIT;
            end
          end else if (scl_fall && byte_done) begin
            next_l.st     = tsl_pkg::L_WACK;
            next_l.sda_oe = 1'b1;
            if (l.byte_idx != 2'h3) begin
              next_l.byte_idx = l.byte_idx + 2'h1;
            end
            if (l.gc) begin
              if (l.byte_idx == 2'h0 && l.shreg == tsl_pkg::GC_RESET_CMD) begin
                next_l.ev_tgl[tsl_pkg::EV_GC] = ~l.ev_tgl[tsl_pkg::EV_GC];
                next_l.ptr = tsl_pkg::PTR_TEMP;
              end
            end else begin
              case (l.byte_idx)
                // pointer changes only on a write
                2'h0: next_l.ptr = l.shreg[1:0];
                2'h1: next_l.msb = l.shreg;
                2'h2: begin
                  next_l.wr = '{ptr: l.ptr, data: {l.msb, l.shreg}};
                  next_l.ev_tgl[tsl_pkg::EV_WR] = ~l.ev_tgl[tsl_pkg::EV_WR];
                end
                default: ;
              endcase
            end
          end
        end
        tsl_pkg::L_AACK: begin
          if (scl_fall) begin
            next_l.bit_cnt = '0;
            if (l.rd_mode) begin
              next_l.st       = tsl_pkg::L_RBYTE;
              next_l.shreg    = l.ara ? {l.my_addr, 1'b0} : l.rd_hold[15:8];
              next_l.sda_oe   = l.ara ? ~l.my_addr[6] : ~l.rd_hold[15];
              next_l.lsb_next = 1'b1;
            end else begin
              next_l.st     = tsl_pkg::L_WBYTE;
              next_l.sda_oe = 1'b0;
            end
          end
        end
        tsl_pkg::L_WACK: begin
          if (scl_fall) begin
            next_l.st      = tsl_pkg::L_WBYTE;
            next_l.bit_cnt = '0;
            next_l.sda_oe  = 1'b0;
          end
        end
        tsl_pkg::L_RBYTE: begin
          if (scl_rise) begin
            next_l.bit_cnt = l.bit_cnt + 4'h1;
          end else if (scl_fall && byte_done) begin
            next_l.st     = tsl_pkg::L_RACK;
            next_l.sda_oe = 1'b0;
          end else if (scl_fall) begin
            // drive out MSB first; low means drive
            next_l.shreg  = {l.shreg[6:0], 1'b0};
            next_l.sda_oe = ~l.shreg[6];
          end
        end
        tsl_pkg::L_RACK: begin
          if (scl_rise && sda_s) begin
            next_l.st = tsl_pkg::L_WAIT;
          end else if (scl_fall) begin
            next_l.st       = tsl_pkg::L_RBYTE;
            next_l.bit_cnt  = '0;
            next_l.shreg    = next_byte;
            next_l.sda_oe   = ~next_byte[7];
            next_l.lsb_next = ~l.lsb_next;
          end
        end
        tsl_pkg::L_IDLE, tsl_pkg::L_WAIT: ;
        default: next_l.st = tsl_pkg::L_IDLE;
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      l <= LINK_RST;
    end else begin
      l <= next_l;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign sda_out             = l.sda_out;
  assign sda_oe              = l.sda_oe;
  assign conv_active         = c.converting;
  assign limit_event_pin_out = c.alert_out;
  assign limit_event_pin_oe  = c.alert;

endmodule : tsl_sensor

`default_nettype wire

// ===== verif/tsl_sensor_props.sv
/* Port checker for tsl_sensor: conversion timing, alert and data line.
   Assumes scl_in comes from a bus master that idles high. */
`timescale 1ns/1ps
`default_nettype none
module tsl_sensor_props #(
  parameter logic [31:0] CONV_CYCLES = 32'h0000_0014,
  parameter logic [31:0] PERIOD_0P25 = 32'h0000_0190
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic conv_active,
  input wire logic limit_event_pin_out,
  input wire logic limit_event_pin_oe
);
  // ********
  // Run lengths and time since reset
  // ********
  logic [31:0] hi_cnt;
  logic [31:0] lo_cnt;
  logic [31:0] up_cnt;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      hi_cnt <= '0;
      lo_cnt <= '0;
      up_cnt <= '0;
    end else begin
      hi_cnt <= conv_active ? hi_cnt + 1 : '0;
      lo_cnt <= conv_active ? '0 : lo_cnt + 1;
      up_cnt <= up_cnt + 1;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // ********
  // Assertions
  // ********
  drive_low_a: assert property (!sda_out && !limit_event_pin_out)
    else $error("open-drain output driven high");
  conv_length_a: assert property ($fell(conv_active) |-> hi_cnt >= CONV_CYCLES)
    else $error("conversion phase too short");
  first_conv_a: assert property ($rose(reset_n) |-> conv_active)
    else $error("no conversion right after reset");
  idle_bound_a: assert property (!conv_active |-> lo_cnt < PERIOD_0P25 - CONV_CYCLES)
    else $error("idle delay longer than slowest rate");
  alert_cause_a: assert property ($rose(limit_event_pin_oe) |->
    conv_active || $past(conv_active) || $past(conv_active, 2))
    else $error("alert raised away from conversion end");
  quiet_start_a: assert property (up_cnt < 32'h0000_03E8 |-> !limit_event_pin_oe)
    else $error("alert active with reset limits");
  bit_stable_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data line moved while clock high");
  ack_timing_a: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 4))
    else $error("device drive not after clock fall");
  cover property ($rose(limit_event_pin_oe));
  cover property ($fell(limit_event_pin_oe));
  cover property ($rose(sda_oe));
endmodule : tsl_sensor_props
bind tsl_sensor tsl_sensor_props #(.CONV_CYCLES(CONV_CYCLES), .PERIOD_0P25(PERIOD_0P25))
  u_props (.ref_clk, .reset_n, .scl_in, .sda_out, .sda_oe, .conv_active,
           .limit_event_pin_out, .limit_event_pin_oe);
`default_nettype wire

// ===== verif/tsl_master.sv
/* Two-wire bus master model with start, stop and byte tasks.
   Assumes the bench resolves the data line with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module tsl_master (
  input  wire logic ref_clk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_low
);
  // ********
  // Bit timing
  // ********
  // Low phase of 140 ns leaves room for the read snapshot crossing
  localparam int Q = 14;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wait_n
  task automatic bit_io(input logic b, output logic r);
    wait_n(Q);
    sda_low = ~b;
    wait_n(Q);
    scl = 1'b1;
    wait_n(2 * Q);
    r = sda;
    scl = 1'b0;
  endtask : bit_io
  // start, repeated when clock is low
  task automatic start;
    if (!scl) begin
      wait_n(Q);
      sda_low = 1'b0;
      wait_n(Q);
      scl = 1'b1;
    end
    wait_n(2 * Q);
    sda_low = 1'b1;
    wait_n(2 * Q);
    scl = 1'b0;
  endtask : start
  task automatic stop;
    wait_n(Q);
    sda_low = 1'b1;
    wait_n(Q);
    scl = 1'b1;
    wait_n(2 * Q);
    sda_low = 1'b0;
    wait_n(2 * Q);
  endtask : stop
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(~more, r);
  endtask : rbyte
endmodule : tsl_master
`default_nettype wire

// ===== verif/tsl_sensor_test.sv
/* Self-checking bench for tsl_sensor driven over the two-wire bus.
   Assumes tsl_master as partner and shortened conversion periods. */
`timescale 1ns/1ps
`default_nettype none
module tsl_sensor_test;
  logic        ref_clk, link_clk, reset_n, pin, sda_low, scl, sda_oe, oe, conv, a;
  logic [11:0] adc;
  logic [15:0] w;
  wire logic   sda;
  int          failures = 0, n_compared = 0, cyc = 0, n;
  logic [15:0] per [4] = '{16'h0190, 16'h00C8, 16'h0064, 16'h0032};
  logic [11:0] tv [3] = '{12'h320, 12'hC90, 12'h000};
  logic [15:0] fv [3] = '{16'h00E0, 16'h00D0, 16'h00C0};
  assign sda = ~(sda_low | sda_oe);
  tsl_sensor #(.CONV_CYCLES(32'h0000_0014), .PERIOD_0P25(32'h0000_0190),
    .PERIOD_1(32'h0000_00C8), .PERIOD_4(32'h0000_0064), .PERIOD_16(32'h0000_0032)
  ) DUT (.ref_clk, .reset_n, .link_clk, .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe,
    .address_select_pin(pin), .adc_result(adc), .conv_active(conv),
    .limit_event_pin_out(), .limit_event_pin_oe(oe));
  tsl_master m (.ref_clk, .sda, .scl, .sda_low);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #7.5 link_clk = ~link_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 99000) begin
      failures++;
      final_report;
    end
  end
  // ********
  // Tasks
  // ********
  task automatic final_report;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_cur(output logic [15:0] v);
    m.start;
    m.wbyte({tsl_pkg::BASE_ADDR[6:1], pin, 1'b1}, a);
    m.rbyte(1'b1, v[15:8]);
    m.rbyte(1'b0, v[7:0]);
    m.stop;
  endtask : rd_cur
  task automatic set_ptr(input logic [1:0] p);
    m.start;
    m.wbyte({tsl_pkg::BASE_ADDR[6:1], pin, 1'b0}, a);
    m.wbyte({6'h00, p}, a);
  endtask : set_ptr
  task automatic rd(input logic [1:0] p, output logic [15:0] v);
    set_ptr(p);
    rd_cur(v);
  endtask : rd
  task automatic wr(input logic [1:0] p, input logic [15:0] d);
    set_ptr(p);
    m.wbyte(d[15:8], a);
    m.wbyte(d[7:0], a);
    m.stop;
  endtask : wr
  task automatic lvl(input logic v, inout int k);
    while (conv !== v && k < 5000) begin
      @(negedge ref_clk);
      k++;
    end
  endtask : lvl
  task automatic wconv(input logic [11:0] t);
    int k;
    k = 0;
    adc = t;
    lvl(1'b1, k);
    lvl(1'b0, k);
    if (k >= 5000) chk(16'h0000, 16'h0001);
  endtask : wconv
  // ********
  // Main sequence
  // ********
  initial begin
    reset_n = 1'b0;
    pin = 1'b0;
    adc = 12'h000;
    repeat (10) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (20) @(negedge ref_clk);
    rd(tsl_pkg::PTR_CFG, w);
    chk(w, 16'h0040);
    rd(tsl_pkg::PTR_LOW, w);
    chk(w, 16'h8000);
    rd(tsl_pkg::PTR_HIGH, w);
    chk(w, 16'h7FF0);
    wr(tsl_pkg::PTR_CFG, 16'hFFFF);
    rd_cur(w);
    chk(w, 16'h02C0);
    for (int r = 0; r < 4; r++) begin
      wr(tsl_pkg::PTR_CFG, {8'h00, r[1:0], 6'h00});
      n = 0;
      lvl(1'b0, n);
      lvl(1'b1, n);
      n = 0;
      lvl(1'b0, n);
      lvl(1'b1, n);
      chk(16'(n), per[r]);
    end
    wr(tsl_pkg::PTR_HIGH, 16'h190F);
    rd_cur(w);
    chk(w, 16'h1900);
    wr(tsl_pkg::PTR_LOW, 16'hE700);
    for (int k = 0; k < 3; k++) begin
      wconv(tv[k]);
      rd(tsl_pkg::PTR_TEMP, w);
      chk(w, {tv[k], 4'h0});
      rd(tsl_pkg::PTR_CFG, w);
      chk(w, fv[k]);
      chk({15'h0000, oe}, {15'h0000, |fv[k][5:4]});
      rd_cur(w);
      chk(w, fv[k]);
    end
    wr(tsl_pkg::PTR_CFG, 16'h02C0);
    wconv(12'h320);
    wconv(12'h000);
    chk({15'h0000, oe}, 16'h0001);
    rd_cur(w);
    chk(w, 16'h02E0);
    chk({15'h0000, oe}, 16'h0000);
    rd_cur(w);
    chk(w, 16'h02C0);
    wconv(12'h320);
    wconv(12'h000);
    m.start;
    m.wbyte({tsl_pkg::ARA_ADDR, 1'b1}, a);
    m.rbyte(1'b0, w[7:0]);
    m.stop;
    chk({8'h00, w[7:0]}, {8'h00, tsl_pkg::BASE_ADDR, 1'b0});
    chk({15'h0000, oe}, 16'h0000);
    rd_cur(w);
    chk(w, 16'h02E0);
    m.start;
    m.wbyte({tsl_pkg::GC_ADDR, 1'b0}, a);
    m.wbyte(tsl_pkg::GC_RESET_CMD, a);
    m.stop;
    rd_cur(w);
    chk(w, 16'h0000);
    rd(tsl_pkg::PTR_HIGH, w);
    chk(w, 16'h7FF0);
    rd(tsl_pkg::PTR_CFG, w);
    chk(w, 16'h0040);
    for (int k = 0; k < 4; k++) begin
      pin = k[1];
      m.start;
      m.wbyte({tsl_pkg::BASE_ADDR[6:1], k[0], 1'b0}, a);
      m.stop;
      chk({15'h0000, a}, {15'h0000, k[0] == k[1]});
    end
    final_report;
  end
endmodule : tsl_sensor_test
`default_nettype wire
